// ===== common/irq_bank_pkg.sv
package irq_bank_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [3:0] CAPTURE3_EN_OFS = 4'h0;
    localparam logic [3:0] PWM_EN_OFS      = 4'h1;
    localparam logic [3:0] FLAGS_A_OFS     = 4'h2;
    localparam logic [3:0] FLAGS_B_OFS     = 4'h3;
    localparam logic [3:0] CORE_CTRL_OFS   = 4'h4;

    // Enable bit positions
    localparam int unsigned CAPTURE3_EN_BIT = 4;
    localparam int unsigned PWM3_TB_BIT     = 6;
    localparam int unsigned PWM2_TB_BIT     = 5;
    localparam int unsigned PWM1_TB_BIT     = 4;
    localparam int unsigned PWM3_SD_BIT     = 2;
    localparam int unsigned PWM2_SD_BIT     = 1;
    localparam int unsigned PWM1_SD_BIT     = 0;

    // Flag and control bit positions
    localparam int unsigned SERIAL_RX_BIT  = 5;
    localparam int unsigned SERIAL_TX_BIT  = 4;
    localparam int unsigned GLOBAL_EN_BIT  = 7;
    localparam int unsigned PERIPH_GATE_BIT = 6;

    // Implemented and writable bit masks
    localparam logic [7:0] CAPTURE3_EN_MASK = 8'h10;
    localparam logic [7:0] PWM_EN_MASK      = 8'h77;
    localparam logic [7:0] FLAGS_A_RO_MASK  = 8'h30;
    localparam logic [7:0] FLAGS_A_WR_MASK  = 8'hCF;
    localparam logic [7:0] FLAGS_B_RO_MASK  = 8'h00;
    localparam logic [7:0] FLAGS_B_WR_MASK  = 8'hFF;
    localparam logic [7:0] CORE_CTRL_MASK   = 8'hC0;

    // Values after any reset
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [7:0] RD_IDLE_VAL   = 8'h00;

    // Writes only the bits that the mask allows
    function automatic logic [7:0] masked_write(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] mask
    );
        masked_write = (old_val & ~mask) | (new_val & mask);
    endfunction

endpackage

// ===== core/irq_flag_reg.sv
`timescale 1ns/1ps
`default_nettype none

module irq_flag_reg #(
    parameter logic [7:0] WR_MASK = 8'hFF,
    parameter logic [7:0] RO_MASK = 8'h00
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_resetn,
    input  wire logic [7:0] i_set,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wr_data,
    input  wire logic [7:0] i_ro_level,
    output var  logic [7:0] o_flags
);

    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] wr_val;
    logic [7:0] set_val;

    // Software write first, then events on top
    assign wr_val  = i_wr_en ? irq_bank_pkg::masked_write(flags_reg, i_wr_data, WR_MASK)
                             : flags_reg; // [RQ12]
    assign set_val = wr_val | (i_set & ~RO_MASK); // [RQ10]
    // Read-only bits track their source, writes ignored
    assign flags_next = (set_val & ~RO_MASK) | (i_ro_level & RO_MASK); // [RQ7]

    // Flag storage
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            flags_reg <= irq_bank_pkg::REG_RESET_VAL; // [RQ9]
        else
            flags_reg <= flags_next;
    end

    assign o_flags = flags_reg;

endmodule // irq_flag_reg

`default_nettype wire

// ===== core/irq_request_merge.sv
`timescale 1ns/1ps
`default_nettype none

module irq_request_merge (
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    input  wire logic [31:0] i_flags,
    input  wire logic [31:0] i_enables,
    input  wire logic        i_periph_gate,
    input  wire logic        i_global_en,
    output var  logic        o_request,
    output var  logic        o_cpu_irq
);

    logic request_next;
    logic cpu_irq_next;
    logic request_reg;
    logic cpu_irq_reg;

    // OR of every flag with its enable, then the two gates
    assign request_next = |(i_flags & i_enables); // [RQ13]
    assign cpu_irq_next = request_next & i_periph_gate & i_global_en; // [RQ5] [RQ13]

    // Registered outputs
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            request_reg <= 1'b0;
            cpu_irq_reg <= 1'b0;
        end
        else
        begin
            request_reg <= request_next;
            cpu_irq_reg <= cpu_irq_next;
        end
    end

    assign o_request = request_reg;
    assign o_cpu_irq = cpu_irq_reg;

endmodule // irq_request_merge

`default_nettype wire

// ===== core/peripheral_irq_enable_flag_bank.sv
// Notes on behaviour
// [RQ1] Bit 4 of the capture-3 enable register is the only writable bit and gates that interrupt.
// [RQ2] Unimplemented bits read as zero and ignore writes.
// [RQ3] Pwm enable bits 6, 5, 4 enable time-base interrupts of controllers three, two, one.
// [RQ4] Pwm enable bits 2, 1, 0 enable shutdown interrupts of three, two, one; bits 7, 3 absent.
// [RQ5] No peripheral interrupt reaches the CPU unless the peripheral gate is set.
// [RQ6] Flag register a holds timer1 gate, adc, rx, tx, sync serial, capture1, timer2, timer1.
// [RQ7] The rx and tx flags are read-only, follow the serial unit and ignore writes.
// [RQ8] Flag register b holds osc fail, cmp2, cmp1, eeprom, collision, cmp4, cmp3, capture2.
// [RQ9] Every implemented enable and flag bit is zero after any reset; one means pending.
// [RQ10] A flag sets on its event regardless of its enable and the global enable.
// [RQ11] Software should clear stale flags before it sets the matching enable.
// [RQ12] Writable bits take software writes that set or clear them; read-only bits do not.
// [RQ13] The request is the OR of each flag AND its enable, then gated by gate and global.

`timescale 1ns/1ps
`default_nettype none

module peripheral_irq_enable_flag_bank (
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_resetn,

    // Register port
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_wr_stb,
    input  wire logic       i_rd_stb,
    output var  logic [7:0] o_rd_data,

    // Event pulses into flag register a
    input  wire logic [7:0] i_flags_a_set,

    // Serial unit levels for the read-only flags
    input  wire logic       i_serial_rx_flag,
    input  wire logic       i_serial_tx_flag,

    // Event pulses into flag register b
    input  wire logic [7:0] i_flags_b_set,

    // Enables for flag registers a and b, held elsewhere
    input  wire logic [7:0] i_flags_a_enable,
    input  wire logic [7:0] i_flags_b_enable,

    // Pending levels of capture-3 and pwm controllers
    input  wire logic       i_capture3_flag,
    input  wire logic [7:0] i_pwm_flags,

    // Enable bits out to the units
    output var  logic       o_capture3_int_en,
    output var  logic [7:0] o_pwm_ctrl_irq_enable,

    // Flag values out
    output var  logic [7:0] o_periph_request_flags_a,
    output var  logic [7:0] o_periph_request_flags_b,

    // Gates out
    output var  logic       o_peripheral_irq_gate,
    output var  logic       o_global_irq_enable,

    // Interrupt outputs
    output var  logic       o_periph_request,
    output var  logic       o_cpu_irq
);

    // Capture-3 enable storage
    logic [7:0] capture3_irq_enable_reg;
    logic [7:0] capture3_irq_enable_next;

    // Pwm enable storage
    logic [7:0] pwm_ctrl_irq_enable_reg;
    logic [7:0] pwm_ctrl_irq_enable_next;

    // Core control storage
    logic [7:0] core_irq_control_reg;
    logic [7:0] core_irq_control_next;

    // Read path
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;

    // Read selection
    logic [7:0] rd_mux;

    // Address decode
    logic       hit_capture3;
    logic       hit_pwm;
    logic       hit_flags_a;
    logic       hit_flags_b;
    logic       hit_core;

    // Write strobes
    logic       wr_capture3;
    logic       wr_pwm;
    logic       wr_flags_a;
    logic       wr_flags_b;
    logic       wr_core;

    // Flag registers
    logic [7:0] periph_request_flags_a;
    logic [7:0] periph_request_flags_b;
    logic [7:0] ro_level_a;
    logic [7:0] zero_level;

    // Merge inputs
    logic [7:0] capture3_flag_vec;
    logic [7:0] pwm_flag_vec;
    logic [31:0] merge_flags;
    logic [31:0] merge_enables;

    // Gate fields
    logic       peripheral_irq_gate;
    logic       global_irq_enable;

    // Enable fields
    logic       capture3_int_en;
    logic       pwm3_timebase_int_en;
    logic       pwm2_timebase_int_en;
    logic       pwm1_timebase_int_en;
    logic       pwm3_shutdown_int_en;
    logic       pwm2_shutdown_int_en;
    logic       pwm1_shutdown_int_en;

    // Address decode of the five registers
    assign hit_capture3 = (i_addr == irq_bank_pkg::CAPTURE3_EN_OFS);
    assign hit_pwm      = (i_addr == irq_bank_pkg::PWM_EN_OFS);
    assign hit_flags_a  = (i_addr == irq_bank_pkg::FLAGS_A_OFS);
    assign hit_flags_b  = (i_addr == irq_bank_pkg::FLAGS_B_OFS);
    assign hit_core     = (i_addr == irq_bank_pkg::CORE_CTRL_OFS);

    // Write strobes per register
    assign wr_capture3 = i_wr_stb & hit_capture3;
    assign wr_pwm      = i_wr_stb & hit_pwm;
    assign wr_flags_a  = i_wr_stb & hit_flags_a;
    assign wr_flags_b  = i_wr_stb & hit_flags_b;
    assign wr_core     = i_wr_stb & hit_core;

    // Capture-3 enable: only bit 4 stores a value
    assign capture3_irq_enable_next = wr_capture3
        ? irq_bank_pkg::masked_write(capture3_irq_enable_reg, i_wr_data,
                                     irq_bank_pkg::CAPTURE3_EN_MASK) // [RQ1] [RQ2]
        : capture3_irq_enable_reg;

    // Pwm enable: bits 7 and 3 stay zero
    assign pwm_ctrl_irq_enable_next = wr_pwm
        ? irq_bank_pkg::masked_write(pwm_ctrl_irq_enable_reg, i_wr_data,
                                     irq_bank_pkg::PWM_EN_MASK) // [RQ3] [RQ4] [RQ2]
        : pwm_ctrl_irq_enable_reg;

    // Core control: global enable and peripheral gate only
    assign core_irq_control_next = wr_core
        ? irq_bank_pkg::masked_write(core_irq_control_reg, i_wr_data,
                                     irq_bank_pkg::CORE_CTRL_MASK) // [RQ2]
        : core_irq_control_reg;

    // Capture-3 enable register
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            capture3_irq_enable_reg <= irq_bank_pkg::REG_RESET_VAL; // [RQ9]
        end
        else
        begin
            capture3_irq_enable_reg <= capture3_irq_enable_next;
        end
    end

    // Pwm enable register
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pwm_ctrl_irq_enable_reg <= irq_bank_pkg::REG_RESET_VAL; // [RQ9]
        end
        else
        begin
            pwm_ctrl_irq_enable_reg <= pwm_ctrl_irq_enable_next;
        end
    end

    // Core control register
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            core_irq_control_reg <= irq_bank_pkg::REG_RESET_VAL;
        end
        else
        begin
            core_irq_control_reg <= core_irq_control_next;
        end
    end

    // Capture-3 enable field
    assign capture3_int_en      = capture3_irq_enable_reg[irq_bank_pkg::CAPTURE3_EN_BIT];

    // Time-base enable fields
    assign pwm3_timebase_int_en = pwm_ctrl_irq_enable_reg[irq_bank_pkg::PWM3_TB_BIT];
    assign pwm2_timebase_int_en = pwm_ctrl_irq_enable_reg[irq_bank_pkg::PWM2_TB_BIT];
    assign pwm1_timebase_int_en = pwm_ctrl_irq_enable_reg[irq_bank_pkg::PWM1_TB_BIT];

    // Shutdown enable fields
    assign pwm3_shutdown_int_en = pwm_ctrl_irq_enable_reg[irq_bank_pkg::PWM3_SD_BIT];
    assign pwm2_shutdown_int_en = pwm_ctrl_irq_enable_reg[irq_bank_pkg::PWM2_SD_BIT];
    assign pwm1_shutdown_int_en = pwm_ctrl_irq_enable_reg[irq_bank_pkg::PWM1_SD_BIT];

    // Named gate fields
    assign global_irq_enable   = core_irq_control_reg[irq_bank_pkg::GLOBAL_EN_BIT];
    assign peripheral_irq_gate = core_irq_control_reg[irq_bank_pkg::PERIPH_GATE_BIT];

    // Serial levels placed at their flag positions
    always_comb
    begin
        ro_level_a = 8'h00;
        ro_level_a[irq_bank_pkg::SERIAL_RX_BIT] = i_serial_rx_flag; // [RQ7]
        ro_level_a[irq_bank_pkg::SERIAL_TX_BIT] = i_serial_tx_flag; // [RQ7]
    end

    // Flag register b has no read-only bits
    assign zero_level = 8'h00;

    // Flag register a: timer1 gate down to timer1 overflow
    irq_flag_reg #(
        .WR_MASK (irq_bank_pkg::FLAGS_A_WR_MASK),
        .RO_MASK (irq_bank_pkg::FLAGS_A_RO_MASK)
    ) u_flags_a (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_set      (i_flags_a_set), // [RQ6] [RQ10]
        .i_wr_en    (wr_flags_a),    // [RQ12]
        .i_wr_data  (i_wr_data),
        .i_ro_level (ro_level_a),    // [RQ7]
        .o_flags    (periph_request_flags_a)
    );

    // Flag register b: osc fail down to capture2
    irq_flag_reg #(
        .WR_MASK (irq_bank_pkg::FLAGS_B_WR_MASK),
        .RO_MASK (irq_bank_pkg::FLAGS_B_RO_MASK)
    ) u_flags_b (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_set      (i_flags_b_set), // [RQ8] [RQ10]
        .i_wr_en    (wr_flags_b),    // [RQ12]
        .i_wr_data  (i_wr_data),
        .i_ro_level (zero_level),
        .o_flags    (periph_request_flags_b)
    );

    // Capture-3 level placed at its enable bit
    always_comb
    begin
        capture3_flag_vec = 8'h00;
        capture3_flag_vec[irq_bank_pkg::CAPTURE3_EN_BIT] = i_capture3_flag;
    end

    // Pwm levels, unimplemented bits dropped
    assign pwm_flag_vec = i_pwm_flags & irq_bank_pkg::PWM_EN_MASK;

    // Flag and enable vectors side by side for the merge
    assign merge_flags   = {periph_request_flags_a,
                            periph_request_flags_b,
                            capture3_flag_vec,
                            pwm_flag_vec};
    assign merge_enables = {i_flags_a_enable,
                            i_flags_b_enable,
                            capture3_irq_enable_reg,
                            pwm_ctrl_irq_enable_reg};

    // Request forming and gating
    irq_request_merge u_merge (
        .i_core_clk    (i_core_clk),
        .i_resetn      (i_resetn),
        .i_flags       (merge_flags),       // [RQ13]
        .i_enables     (merge_enables),     // [RQ13]
        .i_periph_gate (peripheral_irq_gate), // [RQ5]
        .i_global_en   (global_irq_enable),
        .o_request     (o_periph_request),
        .o_cpu_irq     (o_cpu_irq)
    );

    // Read selection, unmapped offsets read zero
    always_comb
    begin
        rd_mux = irq_bank_pkg::RD_IDLE_VAL;
        if (hit_capture3)
        begin
            rd_mux = capture3_irq_enable_reg; // [RQ2]
        end
        else if (hit_pwm)
        begin
            rd_mux = pwm_ctrl_irq_enable_reg; // [RQ2]
        end
        else if (hit_flags_a)
        begin
            rd_mux = periph_request_flags_a;
        end
        else if (hit_flags_b)
        begin
            rd_mux = periph_request_flags_b;
        end
        else if (hit_core)
        begin
            rd_mux = core_irq_control_reg;
        end
    end

    // Read data stands only in the cycle after the strobe
    assign rd_data_next = i_rd_stb
        ? rd_mux
        : irq_bank_pkg::RD_IDLE_VAL;

    // Read data register
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rd_data_reg <= irq_bank_pkg::RD_IDLE_VAL;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
        end
    end

    // Read data out, from its flip-flop
    assign o_rd_data                = rd_data_reg;

    // Enable views, from the enable flip-flops
    assign o_capture3_int_en        = capture3_int_en;
    assign o_pwm_ctrl_irq_enable    = {1'b0,
                                       pwm3_timebase_int_en,
                                       pwm2_timebase_int_en,
                                       pwm1_timebase_int_en,
                                       1'b0,
                                       pwm3_shutdown_int_en,
                                       pwm2_shutdown_int_en,
                                       pwm1_shutdown_int_en};

    // Flag views
    assign o_periph_request_flags_a = periph_request_flags_a;
    assign o_periph_request_flags_b = periph_request_flags_b;

    // Gate views
    assign o_peripheral_irq_gate    = peripheral_irq_gate;
    assign o_global_irq_enable      = global_irq_enable;

endmodule // peripheral_irq_enable_flag_bank

`default_nettype wire

// ===== sim/irq_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none

module irq_bank_checker (
    input wire logic       i_core_clk,
    input wire logic       i_resetn,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic       i_wr_stb,
    input wire logic       i_rd_stb,
    input wire logic [7:0] o_rd_data,
    input wire logic [7:0] i_flags_a_set,
    input wire logic [7:0] i_flags_b_set,
    input wire logic       i_serial_rx_flag,
    input wire logic       i_serial_tx_flag,
    input wire logic [7:0] i_flags_a_enable,
    input wire logic [7:0] i_flags_b_enable,
    input wire logic       i_capture3_flag,
    input wire logic [7:0] i_pwm_flags,
    input wire logic       o_capture3_int_en,
    input wire logic [7:0] o_pwm_ctrl_irq_enable,
    input wire logic [7:0] o_periph_request_flags_a,
    input wire logic [7:0] o_periph_request_flags_b,
    input wire logic       o_peripheral_irq_gate,
    input wire logic       o_periph_request,
    input wire logic       o_cpu_irq
);
    // Ungated pending term over all four sets, each flag masked by its enable
    wire logic pend = |(o_periph_request_flags_a & i_flags_a_enable)
        | |(o_periph_request_flags_b & i_flags_b_enable)
        | (i_capture3_flag & o_capture3_int_en)
        | |(i_pwm_flags & o_pwm_ctrl_irq_enable & 8'h77);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    // Register port strobes
    sequence s_wr(logic [3:0] a);
        i_wr_stb && i_addr == a;
    endsequence
    sequence s_rd(logic [3:0] a);
        i_rd_stb && i_addr == a;
    endsequence
    a_cap3_write: assert property (s_wr(4'h0)
        |=> o_capture3_int_en == $past(i_wr_data[4])) else $error("capture3 enable wrong");
    a_cap3_read: assert property (s_rd(4'h0)
        |=> o_rd_data == {3'h0, $past(o_capture3_int_en), 4'h0}) else $error("capture3 read");
    a_rd_idle: assert property (!$past(i_rd_stb) |-> o_rd_data == 8'h00)
        else $error("read data outside its cycle");
    a_pwm_write: assert property (s_wr(4'h1)
        |=> o_pwm_ctrl_irq_enable == ($past(i_wr_data) & 8'h77)) else $error("pwm enable wrong");
    a_pwm_unused: assert property ((o_pwm_ctrl_irq_enable & 8'h88) == 8'h00)
        else $error("pwm enable bits 7 or 3 set");
    a_gate_blocks: assert property (!$past(o_peripheral_irq_gate)
        |-> !o_cpu_irq) else $error("interrupt without gate");
    a_flags_a_set: assert property (|(i_flags_a_set & 8'hCF)
        |=> (o_periph_request_flags_a & $past(i_flags_a_set) & 8'hCF)
            == ($past(i_flags_a_set) & 8'hCF)) else $error("flag a not set");
    a_serial_follow: assert property ($past(i_resetn)
        |-> o_periph_request_flags_a[5:4] == $past({i_serial_rx_flag, i_serial_tx_flag}))
        else $error("serial flags not following");
    a_flags_b_set: assert property (|i_flags_b_set
        |=> (o_periph_request_flags_b & $past(i_flags_b_set)) == $past(i_flags_b_set))
        else $error("flag b not set");
    a_request_form: assert property ($past(i_resetn) |-> o_periph_request == $past(pend))
        else $error("request term wrong");
endmodule // irq_bank_checker

bind peripheral_irq_enable_flag_bank irq_bank_checker checker_u (
    .i_core_clk, .i_resetn, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb, .o_rd_data,
    .i_flags_a_set, .i_flags_b_set, .i_serial_rx_flag, .i_serial_tx_flag, .i_flags_a_enable,
    .i_flags_b_enable, .i_capture3_flag, .i_pwm_flags, .o_capture3_int_en,
    .o_pwm_ctrl_irq_enable, .o_periph_request_flags_a, .o_periph_request_flags_b,
    .o_peripheral_irq_gate, .o_periph_request, .o_cpu_irq
);

`default_nettype wire

// ===== sim/periph_event_source.sv
`timescale 1ns/1ps
`default_nettype none

module periph_event_source (
    input  wire logic       i_core_clk,
    output var  logic [7:0] o_flags_a_set,
    output var  logic [7:0] o_flags_b_set,
    output var  logic       o_serial_rx_flag,
    output var  logic       o_serial_tx_flag
);
    // Quiet at time zero
    initial
    begin
        o_flags_a_set = 8'h00;
        o_flags_b_set = 8'h00;
        o_serial_rx_flag = 1'b0;
        o_serial_tx_flag = 1'b0;
    end
    // One-cycle event pulses, raised whatever the enables hold
    task automatic pulse(input logic [7:0] a, input logic [7:0] b);
        @(posedge i_core_clk);
        o_flags_a_set <= a;
        o_flags_b_set <= b;
        @(posedge i_core_clk);
        o_flags_a_set <= 8'h00;
        o_flags_b_set <= 8'h00;
    endtask
    // Serial unit status levels
    task automatic serial(input logic rx, input logic tx);
        @(posedge i_core_clk);
        o_serial_rx_flag <= rx;
        o_serial_tx_flag <= tx;
    endtask
endmodule // periph_event_source

`default_nettype wire

// ===== sim/peripheral_irq_enable_flag_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none

module peripheral_irq_enable_flag_bank_tb;
    logic       i_core_clk = 1'b0;
    logic       i_resetn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wr_data = 8'h00;
    logic       i_wr_stb = 1'b0;
    logic       i_rd_stb = 1'b0;
    logic [7:0] i_flags_a_enable = 8'h00;
    logic [7:0] i_flags_b_enable = 8'h00;
    logic       i_capture3_flag = 1'b0;
    logic [7:0] i_pwm_flags = 8'h00;
    wire logic [7:0] i_flags_a_set, i_flags_b_set, o_rd_data, o_pwm_ctrl_irq_enable;
    wire logic [7:0] o_periph_request_flags_a, o_periph_request_flags_b;
    wire logic       i_serial_rx_flag, i_serial_tx_flag, o_capture3_int_en;
    wire logic       o_peripheral_irq_gate, o_global_irq_enable, o_periph_request, o_cpu_irq;
    int              failures = 0;
    int              checks_done = 0;

    // 40 MHz clock
    always #12.5 i_core_clk = ~i_core_clk;

    peripheral_irq_enable_flag_bank dut_u (
        .i_core_clk, .i_resetn, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb, .o_rd_data,
        .i_flags_a_set, .i_serial_rx_flag, .i_serial_tx_flag, .i_flags_b_set, .i_flags_a_enable,
        .i_flags_b_enable, .i_capture3_flag, .i_pwm_flags, .o_capture3_int_en,
        .o_pwm_ctrl_irq_enable, .o_periph_request_flags_a, .o_periph_request_flags_b,
        .o_peripheral_irq_gate, .o_global_irq_enable, .o_periph_request, .o_cpu_irq
    );
    periph_event_source src_u (
        .i_core_clk, .o_flags_a_set(i_flags_a_set), .o_flags_b_set(i_flags_b_set),
        .o_serial_rx_flag(i_serial_rx_flag), .o_serial_tx_flag(i_serial_tx_flag)
    );

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Register port cycles
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr_stb <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_core_clk);
        i_wr_stb <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_rd_stb <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd_stb <= 1'b0;
        #1;
        check(o_rd_data, exp);
    endtask
    // Bounded wait on the interrupt line, then check request and irq
    task automatic wait_irq(input logic exp, input logic [7:0] pair);
        int n = 0;
        while (o_cpu_irq !== exp && n < 8)
        begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        if (o_cpu_irq !== exp)
        begin
            failures++;
            end_of_test();
        end
        check({6'h0, o_periph_request, o_cpu_irq}, pair);
    endtask

    // Reset values and unmapped reads
    task automatic t_reset_values;
        for (int a = 0; a < 6; a++)
            rd(a[3:0], 8'h00);
        rd(4'hF, 8'h00);
    endtask
    // Enable registers: writable and unimplemented bits
    task automatic t_enables;
        wr(4'h0, 8'hFF);
        check({7'h0, o_capture3_int_en}, 8'h01);
        rd(4'h0, 8'h10);
        wr(4'h0, 8'hEF);
        rd(4'h0, 8'h00);
        wr(4'h1, 8'hFF);
        rd(4'h1, 8'h77);
        wr(4'h1, 8'h88);
        rd(4'h1, 8'h00);
        wr(4'hA, 8'hFF);
        rd(4'hA, 8'h00);
    endtask
    // Each event sets its own flag; software sets and clears
    task automatic t_flags;
        for (int i = 0; i < 8; i++)
        begin
            src_u.pulse(8'h01 << i & 8'hCF, 8'h01 << i);
            #1;
            check(o_periph_request_flags_a, 8'h01 << i & 8'hCF);
            check(o_periph_request_flags_b, 8'h01 << i);
            wr(4'h2, 8'h00);
            wr(4'h3, 8'h00);
            check(o_periph_request_flags_b, 8'h00);
        end
        wr(4'h3, 8'hA5);
        rd(4'h3, 8'hA5);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'hCF);
        fork
            src_u.pulse(8'h00, 8'h02);
            wr(4'h3, 8'h00);
        join
        check(o_periph_request_flags_b, 8'h02);
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h00);
    endtask
    // Serial flags follow the unit and ignore writes
    task automatic t_serial;
        src_u.serial(1'b1, 1'b0);
        wr(4'h2, 8'h00);
        check(o_periph_request_flags_a, 8'h20);
        src_u.serial(1'b0, 1'b1);
        wr(4'h2, 8'hEF);
        check(o_periph_request_flags_a, 8'hDF);
        src_u.serial(1'b0, 1'b0);
        wr(4'h2, 8'h00);
    endtask
    // Raise, gate, mask and clear the interrupt
    task automatic t_irq;
        wr(4'h4, 8'h80);
        wr(4'h3, 8'h00);
        @(posedge i_core_clk) i_flags_b_enable <= 8'h08;
        src_u.pulse(8'h00, 8'h08);
        repeat (3) @(posedge i_core_clk);
        #1;
        check({6'h0, o_periph_request, o_cpu_irq}, 8'h02);
        wr(4'h4, 8'hC0);
        wait_irq(1'b1, 8'h03);
        rd(4'h4, 8'hC0);
        check({6'h0, o_peripheral_irq_gate, o_global_irq_enable}, 8'h03);
        @(posedge i_core_clk) i_flags_b_enable <= 8'h00;
        wait_irq(1'b0, 8'h00);
        @(posedge i_core_clk) i_flags_b_enable <= 8'h08;
        wait_irq(1'b1, 8'h03);
        wr(4'h3, 8'h00);
        wait_irq(1'b0, 8'h00);
        wr(4'h0, 8'h10);
        @(posedge i_core_clk) i_capture3_flag <= 1'b1;
        wait_irq(1'b1, 8'h03);
        wr(4'h0, 8'h00);
        wait_irq(1'b0, 8'h00);
        wr(4'h1, 8'h40);
        @(posedge i_core_clk) i_pwm_flags <= 8'hBF;
        repeat (3) @(posedge i_core_clk);
        #1;
        check({6'h0, o_periph_request, o_cpu_irq}, 8'h00);
        @(posedge i_core_clk) i_pwm_flags <= 8'h40;
        wait_irq(1'b1, 8'h03);
    endtask
    // Reset in mid-run clears every register
    task automatic t_mid_reset;
        src_u.pulse(8'h01, 8'h80);
        @(posedge i_core_clk) i_resetn <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1;
        check(o_periph_request_flags_a | o_periph_request_flags_b, 8'h00);
        check(o_pwm_ctrl_irq_enable, 8'h00);
        check({6'h0, o_peripheral_irq_gate, o_global_irq_enable}, 8'h00);
        check({5'h0, o_capture3_int_en, o_periph_request, o_cpu_irq}, 8'h00);
        @(posedge i_core_clk) i_resetn <= 1'b1;
        rd(4'h4, 8'h00);
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        t_reset_values();
        t_enables();
        t_flags();
        t_serial();
        t_irq();
        t_mid_reset();
        end_of_test();
    end
endmodule // peripheral_irq_enable_flag_bank_tb

`default_nettype wire
